/* hw/acc_ctrl.sv */
// Purpose: serial conversion sequencing and shift interface of the converter
// Assumes: pin inputs synchronous to ref_clk; analog core supplies result words
// Notes: conversion timer, counting only in the conversion state, stands in for the modulator
//
// Summary of operation
// - chip select low enables output driver and wakes device from sleep.
// - after every conversion enter sleep and stay while chip select high.
// - chip select rising during shifting, after a rising serial clock edge, aborts and starts new conversion.
// - output driver off while chip select is high.
// - during conversion and sleep output shows status; host reads with select low.
// - internal clock mode drives the serial clock during data output.
// - external clock mode takes the host serial clock as input.
// - clock mode sampled from serial clock on the first cycle after reset release and at each select fall.
// - weak pull-up on serial clock whenever internal mode is in effect.
// - static frequency control level selects the internal oscillator.
// - toggling frequency control selects external clock; notch is rate over 2560.
// - mux address shifted in from sdi on each rising serial clock edge; the last eight bits are kept.
// - result is a 16-bit code with step of reference over two to sixteen.
// - distinct codes for overrange and underrange inputs.
// - data output ends after 19 bits, then a new conversion starts.
// - output data changes on falling serial clock edges.
// - select high before any rising edge returns to sleep, result kept.
// - clock pulses beyond the frame shift out logic high bits.
`timescale 1ns/10ps
module acc_ctrl #(
  parameter int unsigned CONV_LEN = acc_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial pins
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sck_i,
  input wire logic freq_control_input,
  output acc_pkg::acc_pins_t pins,
  // analog core side
  input wire acc_pkg::acc_result_t conv_data,
  output logic conv_start,
  output logic [7:0] mux_addr,
  output logic ext_clk_sel,
  output logic int_sck_mode
);
  import acc_pkg::*;

  // ==========================================================
  // state
  acc_state_t state_q, state_d;
  logic cs_q, cs_d;
  logic sck_q, sck_d;
  logic mode_int_q, mode_int_d;
  logic [31:0] conv_cnt_q, conv_cnt_d;
  logic [18:0] shift_q, shift_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic rose_q, rose_d;
  logic [7:0] mux_sh_q, mux_sh_d;
  logic [7:0] mux_q, mux_d;
  logic isck_q, isck_d;
  logic [7:0] isck_div_q, isck_div_d;
  logic fo_q, fo_d;
  logic [6:0] fo_act_q, fo_act_d;
  logic ext_q, ext_d;
  logic start_q, start_d;
  acc_pins_t pins_q, pins_d;
  logic eoc_n_q, eoc_n_d;
  logic strap_q, strap_d;

  // frame: end-of-conversion flag low, two range flag bits, code
  function automatic logic [18:0] pack_frame(input acc_result_t r);
    logic [1:0] hdr;
    hdr = r.over ? HDR_OVER : (r.under ? HDR_UNDER : 2'h0);
    if (r.over) begin
      pack_frame = {1'b0, hdr, 16'hffff};
    end else if (r.under) begin
      pack_frame = {1'b0, hdr, 16'h0000};
    end else begin
      pack_frame = {1'b0, hdr, r.code};
    end
  endfunction

  // ==========================================================
  // next state
  logic sck_now;
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  always_comb begin
    state_d = state_q;
    cs_d = cs_n;
    mode_int_d = mode_int_q;
    conv_cnt_d = conv_cnt_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    rose_d = rose_q;
    mux_sh_d = mux_sh_q;
    mux_d = mux_q;
    isck_d = isck_q;
    isck_div_d = isck_div_q;
    start_d = 1'b0;
    eoc_n_d = eoc_n_q;
    cs_fall = cs_q & ~cs_n;
    cs_rise = ~cs_q & cs_n;
    // first cycle after release reads the pin strap, later only select falls
    if (cs_fall || !strap_q) begin
      mode_int_d = sck_i;
    end
    // internal clock divider runs only while shifting
    if (state_q == ACC_DOUT && mode_int_q && !cs_n) begin
      if (isck_div_q == 8'(ISCK_HALF_CYCLES - 1)) begin
        isck_div_d = 8'h00;
        isck_d = ~isck_q;
      end else begin
        isck_div_d = isck_div_q + 8'h01;
      end
    end else begin
      isck_div_d = 8'h00;
      isck_d = 1'b1;
    end
    sck_now = mode_int_q ? isck_q : sck_i;
    sck_d = sck_now;
    sck_rise = ~sck_q & sck_now;
    sck_fall = sck_q & ~sck_now;
    case (state_q)
      ACC_CONV: begin
        eoc_n_d = 1'b1;
        if (conv_cnt_q >= CONV_LEN - 1) begin
          conv_cnt_d = '0;
          shift_d = pack_frame(conv_data);
          eoc_n_d = 1'b0;
          state_d = ACC_SLEEP;
        end else begin
          conv_cnt_d = conv_cnt_q + 32'h1;
        end
      end
      ACC_SLEEP: begin
        if (!cs_n) begin
          state_d = ACC_DOUT;
          bit_cnt_d = BIT_CNT_RST;
          rose_d = 1'b0;
        end
      end
      ACC_DOUT: begin
        if (cs_rise) begin
          if (rose_q) begin
            state_d = ACC_CONV;
            start_d = 1'b1;
            mux_d = mux_sh_q;
          end else begin
            state_d = ACC_SLEEP;
          end
        end else begin
          if (sck_rise) begin
            rose_d = 1'b1;
            mux_sh_d = {mux_sh_q[6:0], sdi};
            bit_cnt_d = bit_cnt_q + 5'h01;
          end
          if (sck_fall && rose_q) begin
            shift_d = {shift_q[17:0], 1'b1};
          end
          if (sck_fall && bit_cnt_q == 5'(FRAME_BITS)) begin
            state_d = ACC_CONV;
            start_d = 1'b1;
            mux_d = mux_sh_q;
          end
        end
      end
      default: begin
        state_d = ACC_CONV;
      end
    endcase
  end

  // frequency control: recent toggling means an external clock is present
  always_comb begin
    fo_d = freq_control_input;
    fo_act_d = fo_act_q;
    ext_d = ext_q;
    if (fo_q != freq_control_input) begin
      fo_act_d = 7'(FO_ACT_CYCLES);
      ext_d = 1'b1;
    end else if (fo_act_q != 7'h00) begin
      fo_act_d = fo_act_q - 7'h01;
    end else begin
      ext_d = 1'b0;
    end
  end

  // pin drivers
  always_comb begin
    pins_d.sdo_oe = ~cs_n;
    pins_d.sdo_o = (state_d == ACC_DOUT) ? shift_d[18] : eoc_n_d;
    pins_d.sck_oe = mode_int_d & (state_d == ACC_DOUT) & ~cs_n;
    pins_d.sck_o = isck_d;
    pins_d.sck_pullup = mode_int_d;
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ACC_CONV;
      cs_q <= 1'b1;
      sck_q <= 1'b1;
      mode_int_q <= 1'b1;
      conv_cnt_q <= '0;
      shift_q <= {3'h0, CODE_RST};
      bit_cnt_q <= BIT_CNT_RST;
      rose_q <= 1'b0;
      mux_sh_q <= MUX_RST;
      mux_q <= MUX_RST;
      isck_q <= 1'b1;
      isck_div_q <= 8'h00;
      fo_q <= 1'b0;
      fo_act_q <= 7'h00;
      ext_q <= 1'b0;
      start_q <= 1'b1;
      pins_q <= '0;
      eoc_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cs_q <= cs_d;
      sck_q <= sck_d;
      mode_int_q <= mode_int_d;
      conv_cnt_q <= conv_cnt_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      rose_q <= rose_d;
      mux_sh_q <= mux_sh_d;
      mux_q <= mux_d;
      isck_q <= isck_d;
      isck_div_q <= isck_div_d;
      fo_q <= fo_d;
      fo_act_q <= fo_act_d;
      ext_q <= ext_d;
      start_q <= start_d;
      pins_q <= pins_d;
      eoc_n_q <= eoc_n_d;
    end
  end

  // power-up mode strap caught on the first cycle after release
  always_comb begin
    strap_d = 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_q <= 1'b0;
    end else begin
      strap_q <= strap_d;
    end
  end
  assign pins = pins_q;
  assign conv_start = start_q;
  assign mux_addr = mux_q;
  assign ext_clk_sel = ext_q;
  assign int_sck_mode = mode_int_q;
endmodule // acc_ctrl

/* inc/acc_pkg.sv */
// Purpose: shared constants and types for the serial conversion controller
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: serial pins arrive already synchronous to ref_clk
package acc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CONV_TIME_US = 1000;
  localparam int unsigned CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned FRAME_BITS = 19;
  localparam int unsigned NOTCH_DIV = 2560;
  localparam int unsigned ISCK_HALF_CYCLES = 2;
  localparam int unsigned FO_ACT_CYCLES = 64;
  localparam logic [4:0] BIT_CNT_RST = 5'h00;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [7:0] MUX_RST = 8'h00;
  // the two extra frame bits between the end flag and the code
  localparam logic [1:0] HDR_OVER = 2'h1;
  localparam logic [1:0] HDR_UNDER = 2'h2;

  typedef enum logic [1:0] {
    ACC_CONV = 2'b00,
    ACC_SLEEP = 2'b01,
    ACC_DOUT = 2'b10
  } acc_state_t;

  typedef struct packed {
    logic [15:0] code;
    logic over;
    logic under;
  } acc_result_t;

  typedef struct packed {
    logic sdo_o;
    logic sdo_oe;
    logic sck_o;
    logic sck_oe;
    logic sck_pullup;
  } acc_pins_t;
endpackage

/* sim/acc_ctrl_sva.sv */
// Purpose: port checks for acc_ctrl
// Assumes: one clock domain
// Notes: bound below
`timescale 1ns/10ps
module acc_ctrl_sva
  import acc_pkg::*;
(
  // watched ports
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck_i,
  input wire logic freq_control_input,
  input wire acc_pkg::acc_pins_t pins,
  input wire logic conv_start,
  input wire logic [7:0] mux_addr,
  input wire logic ext_clk_sel,
  input wire logic int_sck_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========
  // checks
  a_oe_cs: assert property (
    !$past(reset) |-> pins.sdo_oe == !$past(cs_n)) else $error("sdo enable");
  a_pull_mode: assert property (
    !$past(reset) |-> pins.sck_pullup == int_sck_mode) else $error("pull-up");
  a_mode_pick: assert property (
    $fell(cs_n) |=> int_sck_mode == $past(sck_i)) else $error("mode");
  a_sck_drive: assert property (
    pins.sck_oe |-> int_sck_mode) else $error("sck drive");
  a_conv_gap: assert property (
    conv_start |=> !conv_start [*8]) else $error("restart");
  a_mux_frame: assert property (
    $changed(mux_addr) |-> conv_start) else $error("mux");
  a_ext_seen: assert property (
    $changed(freq_control_input) |-> ##[1:4] ext_clk_sel) else $error("ext clock");
  a_idle_hiz: assert property (
    cs_n [*3] |-> !pins.sdo_oe && !pins.sck_oe) else $error("idle drive");
  c_frame: cover property ($fell(cs_n) && sck_i);
  c_ext: cover property ($rose(ext_clk_sel));
  c_conv: cover property (conv_start);
endmodule // acc_ctrl_sva

bind acc_ctrl acc_ctrl_sva u_sva (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n),
  .sck_i(sck_i), .freq_control_input(freq_control_input), .pins(pins),
  .conv_start(conv_start), .mux_addr(mux_addr), .ext_clk_sel(ext_clk_sel),
  .int_sck_mode(int_sck_mode));

/* sim/acc_host_model.sv */
// Purpose: host side of the serial pins
// Assumes: pins synchronous to ref_clk
// Notes: sdi always at a valid level
`timescale 1ns/10ps
module acc_host_model
  import acc_pkg::*;
(
  // device pins
  input wire logic ref_clk,
  input wire acc_pkg::acc_pins_t pins,
  output logic cs_n,
  output logic sdi,
  output logic sck_i
);
  logic sck_en, sck_drv;
  logic [20:0] rx;
  event done;
  // device driver wins, then host, then the weak pull-up
  assign sck_i = pins.sck_oe ? pins.sck_o : (sck_en ? sck_drv : pins.sck_pullup);
  initial begin
    cs_n = 1'h1;
    sdi = 1'h0;
    sck_en = 1'h1;
    sck_drv = 1'h1;
    rx = '1;
  end
  task automatic xfer(input logic ext, input logic [18:0] tx, input int n, input logic fire);
    int i;
    sck_drv = !ext;
    sdi = tx[18];
    repeat (2) @(posedge ref_clk);
    #1;
    cs_n = 1'h0;
    rx = '1;
    @(posedge ref_clk);
    #1;
    sck_en = ext;
    for (i = 0; i < n; i++) begin
      if (ext) repeat (3) @(posedge ref_clk);
      else @(posedge sck_i);
      #1;
      sck_drv = 1'h1;
      rx = {rx[19:0], pins.sdo_o};
      repeat (3) @(posedge ref_clk);
      #1;
      sck_drv = 1'h0;
      if (i < 18) sdi = tx[17 - i];
    end
    repeat (4) @(posedge ref_clk);
    #1;
    cs_n = 1'h1;
    sck_en = 1'h1;
    if (fire) ->done;
  endtask
endmodule // acc_host_model

/* sim/test_acc_ctrl.sv */
// Purpose: self-checking bench for acc_ctrl
// Assumes: host model drives the serial pins
// Notes: conversion shortened to 50 cycles
`timescale 1ns/10ps
module test_acc_ctrl;
  import acc_pkg::*;
  logic ref_clk, reset, cs_n, sdi, sck_i, freq_control_input;
  logic conv_start, ext_clk_sel, int_sck_mode;
  logic [7:0] mux_addr;
  logic [20:0] d;
  acc_pins_t pins;
  acc_result_t conv_data, r;
  logic [49:0] exp_q[$];
  logic [49:0] e;
  int err_total, n_checks, seed, i;
  acc_ctrl #(.CONV_LEN(50)) dut (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .sdi(sdi),
    .sck_i(sck_i), .freq_control_input(freq_control_input), .pins(pins),
    .conv_data(conv_data), .conv_start(conv_start), .mux_addr(mux_addr),
    .ext_clk_sel(ext_clk_sel), .int_sck_mode(int_sck_mode));
  acc_host_model host (.ref_clk(ref_clk), .pins(pins), .cs_n(cs_n), .sdi(sdi), .sck_i(sck_i));
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic ok);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("MISMATCH t=%0t check %0d", $time, n_checks);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // header bits of a normal code are left unchecked
  task automatic meas(input logic ext, input logic upd, input int n);
    logic [18:0] f, m;
    logic [7:0] a;
    if (upd) conv_data = r;
    a = 8'($random(seed));
    m = (r.over | r.under) ? '1 : 19'h4ffff;
    f = r.over ? {1'h0, HDR_OVER, 16'hffff} : r.under ? {1'h0, HDR_UNDER, 16'h0000} :
      {3'h0, r.code};
    repeat (60) @(posedge ref_clk);
    #1;
    exp_q.push_back(n > 19 ? {m, 2'h3, f, 2'h3, a} : {2'h0, m, 2'h3, f, a});
    host.xfer(ext, {11'h000, a}, n, 1'h1);
    check(int_sck_mode === !ext);
  endtask
  always @(host.done) begin
    e = exp_q.pop_front();
    d = (host.rx ^ e[28:8]) & e[49:29];
    n_checks++;
    if (d !== 21'h0 || mux_addr !== e[7:0]) begin
      err_total++;
      $display("MISMATCH t=%0t frame %h addr %h", $time, host.rx, mux_addr);
    end
  end
  initial begin
    seed = 32'h9568b1ff;
    err_total = 0;
    n_checks = 0;
    reset = 1'h1;
    freq_control_input = 1'h0;
    conv_data = '0;
    r = '0;
    repeat (12) @(posedge ref_clk);
    #1;
    reset = 1'h0;
    // both clock modes, normal, over and under codes, extra clocks
    for (i = 0; i < 6; i++) begin
      r.code = 16'($random(seed));
      r.over = (i == 2);
      r.under = (i == 3);
      meas(i[0], 1'h1, (i == 5) ? 21 : 19);
    end
    repeat (60) @(posedge ref_clk);
    #1;
    host.xfer(1'h1, 19'h0, 0, 1'h0);
    conv_data = '0;
    meas(1'h1, 1'h0, 19);
    repeat (60) @(posedge ref_clk);
    #1;
    host.xfer(1'h1, 19'h0, 5, 1'h0);
    i = 0;
    while (conv_start !== 1'h1 && i < 4) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    check(conv_start === 1'h1);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      freq_control_input = ~freq_control_input;
    end
    check(ext_clk_sel === 1'h1);
    repeat (100) @(posedge ref_clk);
    #1;
    check(ext_clk_sel === 1'h0);
    stop_test();
  end
  initial begin
    #100us;
    err_total++;
    $display("MISMATCH t=%0t timeout", $time);
    stop_test();
  end
endmodule // test_acc_ctrl
